// ### rtl/lfs_top.sv
// Fault supervisor core of a boost LED driver: comparators in, gate and sink enables out.
// Assumes all comparator and controller inputs are synchronous to clock.
// Contract
// - Input overcurrent shuts everything within 3 us
// - Input overcurrent drives fault low, latches off
// - Overcurrent, even at startup, drops disconnect gate
// - Enable on rise; disable after 50 us fall
// - Primary limit truncates on-time only, no flag
// - Secondary limit shuts all, flags, latches off
// - Latch clears after about 16 ms low
// - Sense trip shuts all, flags, latches off
// - Pin short at startup halts soft-start, flags
// - Open string disabled at overvoltage, flag set
// - Open check in run, short check at startup
// - Confirmed undervoltage turns off, clears latches
// - Overvoltage stops boost until release, no flag
`timescale 1ns/1ps
`include "lfs_cfg.svh"
module lfs_top
#(
  parameter int N = `LFS_STRINGS,
  parameter int RESET_LOW_CYC = `LFS_RESET_LOW_CYC
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic input_undervoltage_lock_rise,
  input wire logic input_undervoltage_lock_fall,
  input wire logic input_sense_trip,
  input wire logic sw_lim1_trip,
  input wire logic sw_lim2_trip,
  input wire logic overvoltage_trip,
  input wire logic overvoltage_release,
  input wire logic en_dim,
  input wire logic softstart_done,
  input wire logic [N-1:0] led_short_gnd,
  input wire logic [N-1:0] led_in_reg,
  output logic disconnect_pmos_on,
  output logic boost_gate_en,
  output logic boost_ontime_end,
  output logic [N-1:0] sink_en,
  output logic softstart_go,
  output logic latched_off,
  output logic fault_n
);
  import lfs_pkg::*;

  typedef struct packed
  {
    lfs_state_t state;
    logic latch_flag;
    logic short_flag;
    logic open_flag;
    logic ovp_hold;
    logic disc;
    logic boost;
    logic trunc;
    logic [N-1:0] sinks;
    logic ss_go;
    logic fault_n;
  } lfs_top_st_t;

  lfs_top_st_t s_q;
  lfs_top_st_t s_d;
  logic input_undervoltage_lock_fall_done;
  logic reset_low_done;
  logic mask_capture;
  logic mask_clear;
  logic [N-1:0] str_off;
  logic hard_trip;
  logic [N-1:0] sink_allow;
  logic [N-1:0] open_new;

  // Every state but OFF has supply; hard trips and the mask clear both key off this
  function automatic logic powered(input lfs_state_t st);
    return (st != LFS_OFF);
  endfunction

  // Falling undervoltage must persist past the deglitch window
  lfs_hold_timer #(.LIMIT(`LFS_INPUT_UNDERVOLTAGE_LOCK_DEGLITCH_CYC)) u_input_undervoltage_lock_filt
  (
    .clock(clock),
    .rstn(rstn),
    .level(input_undervoltage_lock_fall),
    .done(input_undervoltage_lock_fall_done)
  );

  // Counts only while enable/dimming is low; any high cycle restarts it
  lfs_hold_timer #(.LIMIT(RESET_LOW_CYC)) u_reset_low
  (
    .clock(clock),
    .rstn(rstn),
    .level(!en_dim),
    .done(reset_low_done)
  );

  assign mask_capture = (s_q.state == LFS_RUN) && overvoltage_trip;
  assign mask_clear = reset_low_done || !powered(s_q.state);

  lfs_string_mask #(.N(N)) u_mask
  (
    .clock(clock),
    .rstn(rstn),
    .capture(mask_capture),
    .clear(mask_clear),
    .in_reg(led_in_reg),
    .off(str_off)
  );

  // A sink runs with PWM high unless masked; a fresh open is one not yet masked
  for (genvar i = 0; i < N; i++)
  begin : g_str
    assign sink_allow[i] = en_dim && !str_off[i];
    assign open_new[i] = !led_in_reg[i] && !str_off[i];
  end

  assign hard_trip = input_sense_trip || sw_lim2_trip;

  always_comb
  begin
    s_d = s_q;
    // Overvoltage hold: trip sets, release comparator clears
    if (overvoltage_trip)
    begin
      s_d.ovp_hold = 1'b1;
    end
    else if (overvoltage_release)
    begin
      s_d.ovp_hold = 1'b0;
    end
    // Open flag: set wins over the reset-low clear
    if (mask_capture && |open_new)
    begin
      s_d.open_flag = 1'b1;
    end
    else if (reset_low_done)
    begin
      s_d.open_flag = 1'b0;
    end
    unique case (s_q.state)
      LFS_OFF:
      begin
        s_d.latch_flag = 1'b0;
        s_d.short_flag = 1'b0;
        s_d.open_flag = 1'b0;
        if (input_undervoltage_lock_rise)
        begin
          s_d.state = LFS_IDLE;
        end
      end
      LFS_IDLE:
      begin
        if (en_dim)
        begin
          s_d.state = LFS_START;
        end
      end
      LFS_START:
      begin
        // Short check only here; open check is masked during soft-start
        s_d.short_flag = |led_short_gnd;
        if (softstart_done && !(|led_short_gnd))
        begin
          s_d.state = LFS_RUN;
        end
      end
      LFS_RUN:
      begin
        s_d.short_flag = 1'b0;
      end
      LFS_LATCH:
      begin
        if (reset_low_done)
        begin
          s_d.state = LFS_IDLE;
          s_d.latch_flag = 1'b0;
          // Short flag only tracks the pins in START; a stale one would hold fault low
          s_d.short_flag = 1'b0;
        end
      end
      default:
      begin
        s_d.state = LFS_OFF;
      end
    endcase
    // Hard faults latch off from any powered state, startup included
    if (hard_trip && powered(s_q.state))
    begin
      s_d.state = LFS_LATCH;
      s_d.latch_flag = 1'b1;
    end
    // Confirmed undervoltage dominates and wipes every latch
    if (input_undervoltage_lock_fall_done)
    begin
      s_d.state = LFS_OFF;
      s_d.latch_flag = 1'b0;
      s_d.short_flag = 1'b0;
      s_d.open_flag = 1'b0;
      s_d.ovp_hold = 1'b0;
    end
    // Outputs follow the next state so a trip acts on the very next edge
    s_d.disc = 1'b0;
    s_d.boost = 1'b0;
    s_d.sinks = '0;
    s_d.ss_go = 1'b0;
    s_d.trunc = 1'b0;
    unique case (s_d.state)
      LFS_IDLE:
      begin
        s_d.disc = 1'b1;
      end
      LFS_START:
      begin
        s_d.disc = 1'b1;
        if (!s_d.short_flag)
        begin
          s_d.ss_go = 1'b1;
          s_d.boost = !s_d.ovp_hold;
          s_d.sinks = {N{en_dim}};
        end
      end
      LFS_RUN:
      begin
        s_d.disc = 1'b1;
        s_d.ss_go = 1'b1;
        s_d.boost = !s_d.ovp_hold;
        s_d.sinks = sink_allow;
      end
      default:
      begin
        s_d.disc = 1'b0;
      end
    endcase
    // Cycle-by-cycle limit only cuts this on-time; flag and switches untouched
    if (sw_lim1_trip && s_d.boost)
    begin
      s_d.boost = 1'b0;
      s_d.trunc = 1'b1;
    end
    s_d.fault_n = !(s_d.latch_flag || s_d.short_flag || s_d.open_flag);
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      s_q.state <= LFS_OFF;
      s_q.latch_flag <= `LFS_OFF_RST;
      s_q.short_flag <= `LFS_OFF_RST;
      s_q.open_flag <= `LFS_OFF_RST;
      s_q.ovp_hold <= `LFS_OFF_RST;
      s_q.disc <= `LFS_OFF_RST;
      s_q.boost <= `LFS_OFF_RST;
      s_q.trunc <= `LFS_OFF_RST;
      s_q.sinks <= '0;
      s_q.ss_go <= `LFS_OFF_RST;
      s_q.fault_n <= `LFS_FAULT_N_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign disconnect_pmos_on = s_q.disc;
  assign boost_gate_en = s_q.boost;
  assign boost_ontime_end = s_q.trunc;
  assign sink_en = s_q.sinks;
  assign softstart_go = s_q.ss_go;
  assign latched_off = (s_q.state == LFS_LATCH);
  assign fault_n = s_q.fault_n;

endmodule

// ### rtl/lfs_cfg.svh
// Timing and reset constants for the LED driver fault supervisor.
// Assumes a 20 MHz core clock; every count below is derived from it.
`ifndef LFS_CFG_SVH
`define LFS_CFG_SVH

`define LFS_CLK_MHZ 20
// Longest allowed reaction to an input overcurrent trip, in microseconds
`define LFS_SHUTDOWN_MAX_US 3
// Exact, 60 cycles; the design answers in one cycle, far inside this
`define LFS_SHUTDOWN_MAX_CYC (`LFS_SHUTDOWN_MAX_US * `LFS_CLK_MHZ)
// Undervoltage falling deglitch, in microseconds
`define LFS_INPUT_UNDERVOLTAGE_LOCK_DEGLITCH_US 50
// Must be held for more than the time, hence one cycle extra
`define LFS_INPUT_UNDERVOLTAGE_LOCK_DEGLITCH_CYC ((`LFS_INPUT_UNDERVOLTAGE_LOCK_DEGLITCH_US * `LFS_CLK_MHZ) + 1)
// Low time on the enable/dimming input that clears a latched fault, in ms
`define LFS_RESET_LOW_MS 16
`define LFS_RESET_LOW_CYC (`LFS_RESET_LOW_MS * 1000 * `LFS_CLK_MHZ)
// Number of LED strings
`define LFS_STRINGS 6
// Reset values
`define LFS_FAULT_N_RST 1'b1
`define LFS_OFF_RST 1'b0

`endif

// ### rtl/lfs_pkg.sv
// Types shared by the fault supervisor modules.
// Assumes lfs_cfg.svh supplies the numeric constants.
package lfs_pkg;

  typedef enum logic [4:0]
  {
    LFS_OFF = 5'h01,
    LFS_IDLE = 5'h02,
    LFS_START = 5'h04,
    LFS_RUN = 5'h08,
    LFS_LATCH = 5'h10
  } lfs_state_t;

endpackage

// ### rtl/lfs_hold_timer.sv
// Counts consecutive cycles that a level stays high; done once the limit is reached.
// Assumes the level is synchronous to clock.
`timescale 1ns/1ps
module lfs_hold_timer
#(
  parameter int LIMIT = 1001
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic level,
  output logic done
);
  import lfs_pkg::*;

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  typedef struct packed
  {
    logic [CW-1:0] cnt;
  } lfs_tmr_st_t;

  lfs_tmr_st_t s_q;
  lfs_tmr_st_t s_d;

  always_comb
  begin
    s_d = s_q;
    // Any low cycle restarts the count, so glitches never accumulate
    if (!level)
    begin
      s_d.cnt = '0;
    end
    else if (s_q.cnt != LIM)
    begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign done = (s_q.cnt == LIM);

endmodule

// ### rtl/lfs_string_mask.sv
// Per-string disable mask for strings found out of regulation at an overvoltage trip.
// Assumes capture and clear come from the supervisor core.
`timescale 1ns/1ps
module lfs_string_mask
#(
  parameter int N = 6
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic capture,
  input wire logic clear,
  input wire logic [N-1:0] in_reg,
  output logic [N-1:0] off
);
  import lfs_pkg::*;

  typedef struct packed
  {
    logic [N-1:0] off;
  } lfs_mask_st_t;

  lfs_mask_st_t s_q;
  lfs_mask_st_t s_d;

  always_comb
  begin
    s_d = s_q;
    for (int i = 0; i < N; i++)
    begin
      // Capture wins over clear so a trip in the clearing cycle is kept
      if (capture && !in_reg[i])
      begin
        s_d.off[i] = 1'b1;
      end
      else if (clear)
      begin
        s_d.off[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign off = s_q.off;

endmodule

// ### tb/lfs_top_asserts.sv
// Checker for the fault supervisor core, bound into lfs_top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module lfs_top_asserts
#(
  parameter int N = 6,
  parameter int RESET_LOW_CYC = 320000
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic input_undervoltage_lock_fall,
  input wire logic input_sense_trip,
  input wire logic sw_lim1_trip,
  input wire logic sw_lim2_trip,
  input wire logic overvoltage_trip,
  input wire logic en_dim,
  input wire logic [N-1:0] led_short_gnd,
  input wire logic disconnect_pmos_on,
  input wire logic boost_gate_en,
  input wire logic boost_ontime_end,
  input wire logic [N-1:0] sink_en,
  input wire logic latched_off,
  input wire logic fault_n
);
  int low_q;
  int fall_q;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Run lengths; short sims never reach overflow
  always_ff @(posedge clock)
  begin
    low_q <= (!rstn || en_dim) ? 0 : low_q + 1;
    fall_q <= (!rstn || !input_undervoltage_lock_fall) ? 0 : fall_q + 1;
  end
  sense_trip_a:
    assert property (input_sense_trip && disconnect_pmos_on |=> !disconnect_pmos_on
      && !boost_gate_en && sink_en == '0 && !fault_n && latched_off) else $error("sense trip");
  lim2_trip_a:
    assert property (sw_lim2_trip && disconnect_pmos_on |=> !disconnect_pmos_on
      && !boost_gate_en && sink_en == '0 && !fault_n && latched_off) else $error("lim2 trip");
  latch_hold_a:
    assert property (latched_off |-> !fault_n && !disconnect_pmos_on && !boost_gate_en
      && sink_en == '0) else $error("latched state");
  lim1_pulse_a:
    assert property (sw_lim1_trip && boost_gate_en && !input_sense_trip && !sw_lim2_trip
      && !overvoltage_trip && led_short_gnd == '0 |=> boost_ontime_end && disconnect_pmos_on)
      else $error("lim1 pulse");
  lim1_cause_a:
    assert property (boost_ontime_end |-> $past(sw_lim1_trip) && !latched_off)
      else $error("lim1 cause");
  ov_stop_a:
    assert property (overvoltage_trip |=> !boost_gate_en) else $error("ov stop");
  clear_wait_a:
    assert property ($fell(latched_off) && disconnect_pmos_on |-> $past(low_q) >= RESET_LOW_CYC)
      else $error("early clear");
  input_undervoltage_lock_off_a:
    assert property (fall_q >= 1002 |-> !disconnect_pmos_on && !boost_gate_en && sink_en == '0
      && fault_n && !latched_off) else $error("input_undervoltage_lock off");
endmodule
bind lfs_top lfs_top_asserts #(.N(N), .RESET_LOW_CYC(RESET_LOW_CYC)) lfs_top_asserts_inst (
  .clock(clock), .rstn(rstn), .input_undervoltage_lock_fall(input_undervoltage_lock_fall), .input_sense_trip(input_sense_trip),
  .sw_lim1_trip(sw_lim1_trip), .sw_lim2_trip(sw_lim2_trip), .overvoltage_trip(overvoltage_trip),
  .en_dim(en_dim), .led_short_gnd(led_short_gnd), .disconnect_pmos_on(disconnect_pmos_on),
  .boost_gate_en(boost_gate_en), .boost_ontime_end(boost_ontime_end), .sink_en(sink_en),
  .latched_off(latched_off), .fault_n(fault_n));

// ### tb/lfs_ctrl_model.sv
// System controller model driving the enable/dimming input.
// Assumes requests from the bench change at the falling edge.
`timescale 1ns/1ps
module lfs_ctrl_model
#(
  parameter int HOLD = 45
)
(
  input wire logic clock,
  input wire logic on_req,
  input wire logic clr_req,
  output logic en_dim
);
  int cnt = 0;
  initial en_dim = 1'h0;
  always @(negedge clock)
  begin
    if (clr_req && cnt == 0)
      cnt = HOLD;
    else if (cnt > 0)
      cnt = cnt - 1;
    // Hold is longer than the clear count, so one request always clears
    en_dim <= on_req && cnt == 0;
  end
endmodule

// ### tb/lfs_top_tb.sv
// Self-checking bench for lfs_top with a shortened clear count.
// Assumes the controller model supplies en_dim.
`timescale 1ns/1ps
module lfs_top_tb;
  logic clock = 1'h0, rstn = 1'h0, input_undervoltage_lock_rise = 1'h0, input_undervoltage_lock_fall = 1'h0, input_sense_trip = 1'h0;
  logic sw_lim1_trip = 1'h0, sw_lim2_trip = 1'h0, overvoltage_trip = 1'h0, on_req = 1'h0;
  logic overvoltage_release = 1'h0, softstart_done = 1'h0, clr_req = 1'h0;
  logic [5:0] led_short_gnd = 6'h00, led_in_reg = 6'h3F;
  logic en_dim, disconnect_pmos_on, boost_gate_en, boost_ontime_end, softstart_go, latched_off;
  logic fault_n;
  logic [5:0] sink_en;
  logic [7:0] st;
  int fail_count = 0, cmp_count = 0, cyc_n = 0;
  assign st = {fault_n, latched_off, boost_ontime_end, boost_gate_en, disconnect_pmos_on, 3'h0};
  lfs_ctrl_model lfs_ctrl_model_inst (.clock(clock), .on_req(on_req), .clr_req(clr_req),
    .en_dim(en_dim));
  lfs_top #(.N(6), .RESET_LOW_CYC(40)) lfs_top_inst (.clock(clock), .rstn(rstn),
    .input_undervoltage_lock_rise(input_undervoltage_lock_rise), .input_undervoltage_lock_fall(input_undervoltage_lock_fall), .input_sense_trip(input_sense_trip),
    .sw_lim1_trip(sw_lim1_trip), .sw_lim2_trip(sw_lim2_trip), .en_dim(en_dim),
    .overvoltage_trip(overvoltage_trip), .overvoltage_release(overvoltage_release),
    .softstart_done(softstart_done), .led_short_gnd(led_short_gnd), .led_in_reg(led_in_reg),
    .disconnect_pmos_on(disconnect_pmos_on), .boost_gate_en(boost_gate_en),
    .boost_ontime_end(boost_ontime_end), .sink_en(sink_en), .softstart_go(softstart_go),
    .latched_off(latched_off), .fault_n(fault_n));
  initial
  begin
    forever #25 clock = ~clock;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic ck(input logic [7:0] e, input logic [7:0] k);
    chk("outputs", st, e);
    chk("sinks", {2'h0, sink_en}, k);
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic t_start;
    on_req <= 1'h1;
    cyc(3);
    ck(8'h80, 8'h00);
    input_undervoltage_lock_rise <= 1'h1;
    cyc(3);
    ck(8'h98, 8'h3F);
    chk("go", {7'h0, softstart_go}, 8'h01);
    $display("start done");
  endtask
  task automatic t_short;
    led_short_gnd <= 6'h04;
    cyc(1);
    ck(8'h08, 8'h00);
    chk("go", {7'h0, softstart_go}, 8'h00);
    led_short_gnd <= 6'h00;
    overvoltage_trip <= 1'h1;
    led_in_reg <= 6'h3B;
    cyc(1);
    ck(8'h88, 8'h3F);
    overvoltage_trip <= 1'h0;
    overvoltage_release <= 1'h1;
    led_in_reg <= 6'h3F;
    cyc(1);
    ck(8'h98, 8'h3F);
    overvoltage_release <= 1'h0;
    softstart_done <= 1'h1;
    cyc(1);
    led_short_gnd <= 6'h01;
    cyc(1);
    ck(8'h98, 8'h3F);
    led_short_gnd <= 6'h00;
    $display("short done");
  endtask
  task automatic t_lim1;
    sw_lim1_trip <= 1'h1;
    cyc(1);
    ck(8'hA8, 8'h3F);
    sw_lim1_trip <= 1'h0;
    cyc(1);
    ck(8'h98, 8'h3F);
    $display("lim1 done");
  endtask
  task automatic t_open;
    overvoltage_trip <= 1'h1;
    led_in_reg <= 6'h3B;
    cyc(1);
    ck(8'h08, 8'h3F);
    cyc(1);
    ck(8'h08, 8'h3B);
    overvoltage_trip <= 1'h0;
    overvoltage_release <= 1'h1;
    led_in_reg <= 6'h3F;
    cyc(1);
    ck(8'h18, 8'h3B);
    overvoltage_release <= 1'h0;
    $display("open done");
  endtask
  task automatic t_latch;
    input_sense_trip <= 1'h1;
    cyc(1);
    ck(8'h40, 8'h00);
    input_sense_trip <= 1'h0;
    on_req <= 1'h0;
    cyc(30);
    on_req <= 1'h1;
    cyc(1);
    on_req <= 1'h0;
    cyc(30);
    ck(8'h40, 8'h00);
    on_req <= 1'h1;
    clr_req <= 1'h1;
    cyc(1);
    clr_req <= 1'h0;
    cyc(60);
    ck(8'h98, 8'h3F);
    $display("latch done");
  endtask
  task automatic t_lim2;
    sw_lim2_trip <= 1'h1;
    cyc(1);
    ck(8'h40, 8'h00);
    sw_lim2_trip <= 1'h0;
    $display("lim2 done");
  endtask
  task automatic t_input_undervoltage_lock;
    input_undervoltage_lock_fall <= 1'h1;
    cyc(1000);
    input_undervoltage_lock_fall <= 1'h0;
    cyc(1);
    ck(8'h40, 8'h00);
    input_undervoltage_lock_rise <= 1'h0;
    input_undervoltage_lock_fall <= 1'h1;
    cyc(1003);
    ck(8'h80, 8'h00);
    input_undervoltage_lock_fall <= 1'h0;
    $display("input_undervoltage_lock done");
  endtask
  task automatic t_boot_trip;
    softstart_done <= 1'h0;
    input_undervoltage_lock_rise <= 1'h1;
    cyc(3);
    ck(8'h98, 8'h3F);
    input_sense_trip <= 1'h1;
    cyc(1);
    ck(8'h40, 8'h00);
    input_sense_trip <= 1'h0;
    $display("boot trip done");
  endtask
  always @(posedge clock)
  begin
    cyc_n++;
    if (cyc_n == 5000)
    begin
      fail_count++;
      stop_test;
    end
  end
  initial
  begin
    cyc(10);
    rstn <= 1'h1;
    cyc(1);
    t_start;
    t_short;
    t_lim1;
    t_open;
    t_latch;
    t_lim2;
    t_input_undervoltage_lock;
    t_boot_trip;
    stop_test;
  end
endmodule
